// ===== sac_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// analog front end; input level given as an offset code
module sac_analog_model (
  // analog input and trial code from the converter
  input wire logic [9:0] level,
  input wire logic [9:0] trialCode,
  // comparator decision back to the converter
  output logic           compAbove
);
  assign compAbove = (level >= trialCode);
endmodule // sac_analog_model
`default_nettype wire

// ===== sac_conversion_control.v
`include "sac_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module sac_conversion_control #(
  parameter WIDTH   = `SAC_RES_BITS,
  parameter STEPDIV = `SAC_STEP_DIV
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             resetn,

  // host request line, active low, asynchronous pin
  input  wire             blankConvert_n,

  // range pin: low = tied to common (unipolar), high = open (bipolar)
  input  wire             rangeOpen,

  // comparator: high when input is at or above the trial value
  input  wire             compAbove,

  // trial code to the internal dac
  output reg  [WIDTH-1:0] trialCode,

  // bipolar offset current switch
  output reg              bipolarOffsetOn,

  // three-state result pins, oe low means driven
  output reg  [WIDTH-1:0] dataOut,
  output reg              dataOe_n,

  // completion flag, open drain: out always low, oe low pulls low
  // the far end supplies the pull-up for the released level
  output wire             ready_n,
  output reg              readyOe_n
);
  // one-hot states
  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_DONE = 3'b100;

  // timing budget: a conversion is WIDTH+1 steps of STEPDIV cycles plus
  // about four cycles of pin synchronising; the default divide of 227 on a
  // 125 MHz clock gives 2497 cycles, near 20 us and inside 15 to 30 us.
  // a short divide speeds simulation but leaves that window on purpose

  // sequencer state
  reg [2:0]        state;
  reg [2:0]        next_state;

  // pin synchronisers; only the second stage is read by logic
  reg              reqMeta;
  reg              reqSync;
  reg              rngMeta;
  reg              rngSync;
  reg              cmpMeta;
  reg              cmpSync;

  // approximation datapath
  reg  [WIDTH-1:0] probe;      // one-hot bit under trial
  reg  [WIDTH-1:0] sar;        // bits decided so far
  wire [WIDTH-1:0] next_probe;
  wire [WIDTH-1:0] next_sar;
  wire [WIDTH-1:0] next_trial;

  // step timing and decode
  wire             stepEn;
  wire             startConv;  // idle to converting this cycle
  wire             takeStep;   // one bit decided this cycle
  wire             finishConv; // last step commits the flag

  // open-drain pin only ever pulls low; the pull-up gives the high level
  assign ready_n = 1'b0;

  // step decode shared by the datapath and the result logic
  assign startConv  = (state == ST_IDLE) && !reqSync;
  assign takeStep   = (state == ST_CONV) && stepEn &&
                      (probe != {WIDTH{1'b0}});
  assign finishConv = (state == ST_CONV) && !reqSync && stepEn &&
                      (probe == {WIDTH{1'b0}});

  // per-bit approximation: the bit on trial takes the comparator
  // decided bits hold, and the next lower bit is raised for trial
  assign next_probe = probe >> 1;
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      // keep the trial bit only when the input sits at or above it
      assign next_sar[gi]   = probe[gi] ? cmpSync : sar[gi];
      assign next_trial[gi] = probe[gi] ? cmpSync
                                        : (sar[gi] | next_probe[gi]);
    end
  endgenerate

  // internal step clock
  // restarted per conversion so every conversion takes the same time
  sac_step_clock #(
    .DIV    (STEPDIV)
  ) u_step (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .run     (state == ST_CONV),
    .stepEn  (stepEn)
  );

  // pin synchronisers, two flops each; the request resets to its idle
  // high level, so no false start follows reset
  always @(posedge clk_sys) begin
    if (!resetn) begin
      reqMeta <= 1'b1;
      reqSync <= 1'b1;
      rngMeta <= 1'b0;
      rngSync <= 1'b0;
      cmpMeta <= 1'b0;
      cmpSync <= 1'b0;
    end else begin
      reqMeta <= blankConvert_n;
      reqSync <= reqMeta;
      rngMeta <= rangeOpen;
      rngSync <= rngMeta;
      // compAbove only matters at a step, long after it has settled
      cmpMeta <= compAbove;
      cmpSync <= cmpMeta;
    end
  end

  // sequencing; a request still low while done is simply held
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (!reqSync)
          next_state = ST_CONV;
      end
      ST_CONV: begin
        if (reqSync)
          next_state = ST_IDLE;
        // done only after the extra flag step
        else if (stepEn && probe == {WIDTH{1'b0}})
          next_state = ST_DONE;
      end
      // result held while the request stays low
      ST_DONE: begin
        if (reqSync)
          next_state = ST_IDLE;
      end
      // unused codes fall back to idle
      default: next_state = ST_IDLE;
    endcase
  end

  // state register
  always @(posedge clk_sys) begin
    if (!resetn)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // approximation register; trial code and decisions move only at the start and on a step
  // so the comparator has a full step to settle through its synchroniser
  always @(posedge clk_sys) begin
    if (!resetn) begin
      probe           <= {WIDTH{1'b0}};
      sar             <= {WIDTH{1'b0}};
      trialCode       <= {WIDTH{1'b0}};
      bipolarOffsetOn <= 1'b0;
    end else if (startConv) begin
      probe           <= {1'b1, {(WIDTH-1){1'b0}}};
      sar             <= {WIDTH{1'b0}};
      trialCode       <= {1'b1, {(WIDTH-1){1'b0}}};
      // range latched per conversion so a moving pin cannot mix
      bipolarOffsetOn <= rngSync;
    end else if (takeStep) begin
      // one bit per step, top bit first
      probe     <= next_probe;
      sar       <= next_sar;
      trialCode <= next_trial;
    end
  end

  // result pins and flag; the last step only commits the flag, giving
  // WIDTH+1 steps; a release mid conversion drops the partial result
  // code is straight binary of the offset-shifted input
  // so bipolar reads as offset binary with no recoding
  always @(posedge clk_sys) begin
    if (!resetn) begin
      dataOut   <= {WIDTH{1'b0}};
      dataOe_n  <= 1'b1;
      readyOe_n <= 1'b1;
    end else if (finishConv) begin
      dataOut   <= sar;
      // flag low after the last step
      readyOe_n <= 1'b0;
      dataOe_n  <= 1'b0;
    end else if (next_state == ST_IDLE) begin
      readyOe_n <= 1'b1;
      dataOe_n  <= 1'b1;
    end
  end
endmodule // sac_conversion_control
`default_nettype wire

// ===== sac_conversion_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// watches the converter pins; counts how long the request has been low
module sac_chk #(
  parameter WIDTH   = 10,
  parameter STEPDIV = 227
) (
  // clock and reset
  input wire logic             clk_sys,
  input wire logic             resetn,
  // host side and comparator
  input wire logic             blankConvert_n,
  input wire logic             rangeOpen,
  input wire logic             compAbove,
  // converter outputs
  input wire logic [WIDTH-1:0] trialCode,
  input wire logic [WIDTH-1:0] dataOut,
  input wire logic             bipolarOffsetOn,
  input wire logic             dataOe_n,
  input wire logic             ready_n,
  input wire logic             readyOe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [15:0] lowCnt;
  // request low cycle counter, cleared whenever the host releases
  always_ff @(posedge clk_sys) begin
    lowCnt <= blankConvert_n ? 16'h0 : lowCnt + 16'h1;
  end
  chk_oe_paired: assert property (dataOe_n == readyOe_n)
    else $error("flag and pins differ");
  chk_min_time: assert property ($fell(readyOe_n) |->
    lowCnt >= (WIDTH + 1) * STEPDIV) else $error("done too early");
  chk_max_time: assert property (readyOe_n && !blankConvert_n |->
    lowCnt <= (WIDTH + 1) * STEPDIV + 6) else $error("done too late");
  chk_blank_off: assert property (blankConvert_n [*4] |-> dataOe_n)
    else $error("pins driven while blanked");
  chk_hold_done: assert property (!dataOe_n && !blankConvert_n |=>
    !dataOe_n) else $error("result dropped");
  chk_data_stable: assert property (!dataOe_n && !$past(dataOe_n) |->
    $stable(dataOut)) else $error("result moved");
  chk_msb_first: assert property ($fell(blankConvert_n) && dataOe_n |->
    ##[1:4] trialCode == 10'h200) else $error("top bit not tried first");
  chk_range_sel: assert property (!dataOe_n |->
    bipolarOffsetOn == $past(rangeOpen, 8)) else $error("range wrong");
endmodule // sac_chk
bind sac_conversion_control sac_chk #(.WIDTH(WIDTH), .STEPDIV(STEPDIV))
  u_sac_chk (
  .clk_sys         (clk_sys),
  .resetn          (resetn),
  .blankConvert_n  (blankConvert_n),
  .rangeOpen       (rangeOpen),
  .compAbove       (compAbove),
  .trialCode       (trialCode),
  .dataOut         (dataOut),
  .bipolarOffsetOn (bipolarOffsetOn),
  .dataOe_n        (dataOe_n),
  .ready_n         (ready_n),
  .readyOe_n       (readyOe_n)
);
`default_nettype wire

// ===== sac_defines.vh
`ifndef SAC_DEFINES_VH
`define SAC_DEFINES_VH
// result width
`define SAC_RES_BITS 10
// bipolar zero code, the only bit set is the top one
`define SAC_BIPOLAR_MID 10'h200
// conversion time figures in ns
`define SAC_TCONV_MIN_NS 15000
`define SAC_TCONV_TYP_NS 25000
`define SAC_TCONV_MAX_NS 30000
// system clock period in ns
`define SAC_CLK_NS 8
// internal step clock divide ratio (one bit per step)
`define SAC_STEP_DIV 227
`endif

// ===== sac_step_clock.v
`timescale 1ns/1ps
`default_nettype none
// internal conversion clock: one-cycle enable every DIV cycles while run
module sac_step_clock #(
  parameter DIV = 227
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       resetn,
  // control
  input  wire       run,
  output reg        stepEn
);
  // terminal count held at the counter's own width
  localparam [15:0] DIV_LAST = DIV - 1;

  reg [15:0] count;

  // divider restarts whenever run drops so every conversion is timed alike
  always @(posedge clk_sys) begin
    if (!resetn || !run) begin
      count  <= 16'h0000;
      stepEn <= 1'b0;
    end else if (count == DIV_LAST) begin
      count  <= 16'h0000;
      stepEn <= 1'b1;
    end else begin
      count  <= count + 16'h0001;
      stepEn <= 1'b0;
    end
  end
endmodule // sac_step_clock
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam SD = 8;
  logic       clk_sys = 1'b0, resetn = 1'b0, req = 1'b1, rng = 1'b0;
  logic [9:0] lvl = 10'h0, trialCode, dataOut;
  logic       cmp, bip, dataOe_n, ready_n, readyOe_n;
  // completion line as the host sees it: pulled up when released
  wire        readyPin = readyOe_n ? 1'b1 : ready_n;
  int         n_errors = 0, n_compared = 0;
  sac_conversion_control #(.STEPDIV(SD)) u_sac_conversion_control (
    .clk_sys(clk_sys), .resetn(resetn), .blankConvert_n(req),
    .rangeOpen(rng), .compAbove(cmp), .trialCode(trialCode),
    .bipolarOffsetOn(bip), .dataOut(dataOut), .dataOe_n(dataOe_n),
    .ready_n(ready_n), .readyOe_n(readyOe_n));
  sac_analog_model u_sac_analog_model (.level(lvl),
    .trialCode(trialCode), .compAbove(cmp));
  initial forever #4 clk_sys = ~clk_sys;
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // full cycle: request low, bounded wait for done, read, release
  task automatic convert(input logic r, input logic [9:0] l);
    int i;
    @(posedge clk_sys) rng <= r;
    lvl <= l;
    @(posedge clk_sys) req <= 1'b0;
    for (i = 0; i < 20 * SD && readyPin !== 1'b0; i++) @(negedge clk_sys);
    check(10'(readyPin), 10'h0);
    if (readyPin !== 1'b0) end_sim();
    check(dataOut, l);
    check(10'(dataOe_n), 10'h0);
    check(10'(bip), 10'(r));
    @(posedge clk_sys) req <= 1'b1;
    repeat (5) @(negedge clk_sys);
    check(10'(dataOe_n), 10'h1);
    check(10'(readyPin), 10'h1);
  endtask
  // release mid conversion: pins must stay undriven afterwards
  task automatic abort_conv;
    @(posedge clk_sys) req <= 1'b0;
    repeat (4 * SD) @(posedge clk_sys);
    req <= 1'b1;
    repeat (20 * SD) @(negedge clk_sys) check(10'(dataOe_n), 10'h1);
    check(10'(readyPin), 10'h1);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    convert(1'b0, 10'h3FF);
    convert(1'b0, 10'h155);
    convert(1'b1, 10'h200);
    convert(1'b1, 10'h000);
    abort_conv();
    convert(1'b1, 10'h3FF);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
